//--- hw/rsc_pkg.sv
// constants and carrier types of the ramp and status capture register bank
package rsc_pkg;
  // ************************************************
  // command codes
  // ************************************************
  localparam logic [7:0] CMD_RAMP_REC  = 8'hDB;
  localparam logic [7:0] CMD_TEMP_SEL  = 8'hDC;
  localparam logic [7:0] CMD_VIN_OFS   = 8'hDD;
  localparam logic [7:0] CMD_VOUT_TRIM = 8'hDE;
  localparam logic [7:0] CMD_STAT_HIST = 8'hDF;

  // ************************************************
  // record layout
  // ************************************************
  localparam int RAMP_PAIRS = 15;
  localparam int STAT_WORDS = 16;
  localparam int SAMPLE_W   = 8;
  localparam int CNT_W      = 16;
  localparam int STAT_W     = 16;
  localparam int BLOCK_W    = 256;
  localparam int PAIR_LSB   = 16;   // pair k: vin at 16+16k, vout 8 above
  localparam int PAIR_STEP  = 16;
  localparam int TEMP_EXT_BIT = 0;
  localparam int VIN_ON_LSB   = 16;
  localparam int VIN_OFF_LSB  = 0;
  localparam int HALF_W       = 16;

  // response lengths in bytes
  localparam logic [5:0] LEN_NONE  = 6'h00;
  localparam logic [5:0] LEN_BYTE  = 6'h01;
  localparam logic [5:0] LEN_WORD  = 6'h02;
  localparam logic [5:0] LEN_DWORD = 6'h04;
  localparam logic [5:0] LEN_BLOCK = 6'h20;

  // reset values
  localparam logic [7:0]  TEMP_SEL_RST  = 8'h00;
  localparam logic [31:0] VIN_OFS_RST   = 32'h0000_0000;
  localparam logic [15:0] VOUT_TRIM_RST = 16'h0000;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_HZ          = 125_000_000;
  localparam int STAT_PERIOD_S   = 8;
  localparam int STAT_PERIOD_CYC = STAT_PERIOD_S * CLK_HZ;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {RAMP_IDLE = 2'b00, RAMP_CAPT = 2'b01, RAMP_HELD = 2'b11} rsc_ramp_e;
  typedef enum logic [1:0] {HIST_IDLE = 2'b00, HIST_RUN = 2'b01, HIST_FULL = 2'b11} rsc_hist_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [31:0] wdata;
  } rsc_cmd_s;

  typedef struct packed {
    logic         valid;
    logic         err;
    logic [5:0]   len;
    logic [255:0] data;
  } rsc_rsp_s;

  typedef struct packed {
    logic [7:0]  temp_sel;
    logic [15:0] vin_on;
    logic [15:0] vin_off;
    logic [15:0] vout_trim;
  } rsc_cfg_s;
endpackage : rsc_pkg

//--- hw/rsc_ramp_status_regs.sv
// ramp recorder, status history recorder and small config registers
//
// Contract
// - ramp record read returns 32 bytes: counter then start-up voltage samples
// - fifteen vin/vout pairs captured during the ramp, spaced by one fifteenth of ramp duration
// - just before ramp, latch counter as last snapshot count plus one
// - only the first ramp after power-up is recorded
// - stored ramp record is cleared after a successful ramp-up
// - counter in 15:0, pair k vin below vout from bit 16, up to pair 14
// - status history read returns sixteen 16-bit words, word 0 lowest
// - history starts after ramp ends, one word every 8 s, sixteen words
// - temperature select bit 0: 0 internal sensor, 1 external sensor
// - input offset register: turn-on in 31:16, turn-off in 15:0
// - output trim register holds signed 16-bit value in 15:0
module rsc_ramp_status_regs
  import rsc_pkg::*;
#(
  parameter int STAT_PERIOD = STAT_PERIOD_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire rsc_cmd_s            cmd,
  input  wire logic                ramp_start,
  input  wire logic                ramp_done,
  input  wire logic                ramp_ok,
  input  wire logic [31:0]         ramp_cycles,
  input  wire logic [CNT_W-1:0]    snap_cycles,
  input  wire logic [SAMPLE_W-1:0] vin_sample,
  input  wire logic [SAMPLE_W-1:0] vout_sample,
  input  wire logic [STAT_W-1:0]   status_word,
  output rsc_rsp_s                 rsp,
  output rsc_cfg_s                 cfg
);

  // ************************************************
  // ramp recorder
  // ************************************************
  rsc_ramp_e           ramp_st_reg, ramp_st_next;
  logic [31:0]         intv_cnt_reg, intv_cnt_next;
  logic [3:0]          pair_idx_reg, pair_idx_next;
  logic [CNT_W-1:0]    rec_cnt_reg, rec_cnt_next;
  logic [SAMPLE_W-1:0] vin_mem_reg  [RAMP_PAIRS];
  logic [SAMPLE_W-1:0] vin_mem_next [RAMP_PAIRS];
  logic [SAMPLE_W-1:0] vout_mem_reg [RAMP_PAIRS];
  logic [SAMPLE_W-1:0] vout_mem_next[RAMP_PAIRS];
  logic [31:0]         intv_last;

  // even split of the ramp, never below one cycle
  always_comb begin
    logic [31:0] q;
    q = ramp_cycles / 32'(RAMP_PAIRS);
    intv_last = (q == 32'h0) ? 32'h0 : q - 32'h1;
  end

  // ramp next state: capture once, hold until power cycles
  always_comb begin
    ramp_st_next  = ramp_st_reg;
    intv_cnt_next = intv_cnt_reg;
    pair_idx_next = pair_idx_reg;
    rec_cnt_next  = rec_cnt_reg;
    vin_mem_next  = vin_mem_reg;
    vout_mem_next = vout_mem_reg;
    unique case (ramp_st_reg)
      RAMP_IDLE: begin
        if (ramp_start) begin
          rec_cnt_next  = snap_cycles + CNT_W'(1);
          intv_cnt_next = 32'h0;
          pair_idx_next = 4'h0;
          ramp_st_next  = RAMP_CAPT;
        end
      end
      RAMP_CAPT: begin
        if (intv_cnt_reg >= intv_last) begin
          vin_mem_next[pair_idx_reg]  = vin_sample;
          vout_mem_next[pair_idx_reg] = vout_sample;
          intv_cnt_next = 32'h0;
          pair_idx_next = pair_idx_reg + 4'h1;
          if (pair_idx_reg == 4'(RAMP_PAIRS - 1)) ramp_st_next = RAMP_HELD;
        end else begin
          intv_cnt_next = intv_cnt_reg + 32'h1;
        end
        // a short ramp simply stops the sampling
        if (ramp_done) ramp_st_next = RAMP_HELD;
      end
      RAMP_HELD: begin
        ramp_st_next = RAMP_HELD;
      end
      default: ramp_st_next = RAMP_HELD;
    endcase
    // a good ramp-up wipes the record; the state still blocks re-capture
    if (ramp_ok && ramp_st_reg != RAMP_IDLE) begin
      rec_cnt_next = '0;
      for (int i = 0; i < RAMP_PAIRS; i++) begin
        vin_mem_next[i]  = '0;
        vout_mem_next[i] = '0;
      end
      ramp_st_next = RAMP_HELD;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ramp_st_reg  <= RAMP_IDLE;
      intv_cnt_reg <= 32'h0;
      pair_idx_reg <= 4'h0;
      rec_cnt_reg  <= '0;
      for (int i = 0; i < RAMP_PAIRS; i++) begin
        vin_mem_reg[i]  <= '0;
        vout_mem_reg[i] <= '0;
      end
    end else begin
      ramp_st_reg  <= ramp_st_next;
      intv_cnt_reg <= intv_cnt_next;
      pair_idx_reg <= pair_idx_next;
      rec_cnt_reg  <= rec_cnt_next;
      vin_mem_reg  <= vin_mem_next;
      vout_mem_reg <= vout_mem_next;
    end
  end

  // ************************************************
  // status history recorder
  // ************************************************
  rsc_hist_e         hist_st_reg, hist_st_next;
  logic [31:0]       per_cnt_reg, per_cnt_next;
  logic [4:0]        word_idx_reg, word_idx_next;
  logic [STAT_W-1:0] stat_mem_reg [STAT_WORDS];
  logic [STAT_W-1:0] stat_mem_next[STAT_WORDS];

  // word 0 right at ramp end, then one per period
  always_comb begin
    hist_st_next  = hist_st_reg;
    per_cnt_next  = per_cnt_reg;
    word_idx_next = word_idx_reg;
    stat_mem_next = stat_mem_reg;
    unique case (hist_st_reg)
      HIST_IDLE: begin
        if (ramp_done) begin
          stat_mem_next[0] = status_word;
          word_idx_next    = 5'h1;
          per_cnt_next     = 32'h0;
          hist_st_next     = HIST_RUN;
        end
      end
      HIST_RUN: begin
        if (per_cnt_reg == 32'(STAT_PERIOD - 1)) begin
          stat_mem_next[word_idx_reg[3:0]] = status_word;
          per_cnt_next  = 32'h0;
          word_idx_next = word_idx_reg + 5'h1;
          if (word_idx_reg == 5'(STAT_WORDS - 1)) hist_st_next = HIST_FULL;
        end else begin
          per_cnt_next = per_cnt_reg + 32'h1;
        end
      end
      HIST_FULL: hist_st_next = HIST_FULL;
      default:   hist_st_next = HIST_FULL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hist_st_reg  <= HIST_IDLE;
      per_cnt_reg  <= 32'h0;
      word_idx_reg <= 5'h0;
      for (int i = 0; i < STAT_WORDS; i++) stat_mem_reg[i] <= '0;
    end else begin
      hist_st_reg  <= hist_st_next;
      per_cnt_reg  <= per_cnt_next;
      word_idx_reg <= word_idx_next;
      stat_mem_reg <= stat_mem_next;
    end
  end

  // ************************************************
  // command port and config registers
  // ************************************************
  rsc_rsp_s rsp_next;
  rsc_cfg_s cfg_next;

  // reply length per code; zero marks an unmapped code
  function automatic logic [5:0] cmd_len(input logic [7:0] code);
    unique case (code)
      CMD_RAMP_REC, CMD_STAT_HIST: cmd_len = LEN_BLOCK;
      CMD_TEMP_SEL:                cmd_len = LEN_BYTE;
      CMD_VIN_OFS:                 cmd_len = LEN_DWORD;
      CMD_VOUT_TRIM:               cmd_len = LEN_WORD;
      default:                     cmd_len = LEN_NONE;
    endcase
  endfunction

  // decode, write config, build the one-cycle reply
  always_comb begin
    cfg_next       = cfg;
    rsp_next       = '0;
    rsp_next.valid = cmd.valid;
    rsp_next.len   = cmd_len(cmd.code);
    if (cmd.valid) begin
      if (cmd.write) begin
        rsp_next.len = LEN_NONE;
        unique case (cmd.code)
          CMD_TEMP_SEL:  cfg_next.temp_sel  = cmd.wdata[7:0];
          CMD_VIN_OFS: begin
            cfg_next.vin_on  = cmd.wdata[VIN_ON_LSB +: HALF_W];
            cfg_next.vin_off = cmd.wdata[VIN_OFF_LSB +: HALF_W];
          end
          CMD_VOUT_TRIM: cfg_next.vout_trim = cmd.wdata[HALF_W-1:0];
          default:       rsp_next.err = 1'b1; // read-only or unmapped
        endcase
      end else begin
        unique case (cmd.code)
          CMD_RAMP_REC: begin
            rsp_next.data[CNT_W-1:0] = rec_cnt_reg;
            for (int k = 0; k < RAMP_PAIRS; k++) begin
              rsp_next.data[PAIR_LSB + PAIR_STEP*k +: SAMPLE_W]            = vin_mem_reg[k];
              rsp_next.data[PAIR_LSB + PAIR_STEP*k + SAMPLE_W +: SAMPLE_W] = vout_mem_reg[k];
            end
          end
          CMD_STAT_HIST: begin
            for (int k = 0; k < STAT_WORDS; k++)
              rsp_next.data[STAT_W*k +: STAT_W] = stat_mem_reg[k];
          end
          CMD_TEMP_SEL:  rsp_next.data[7:0]        = cfg.temp_sel;
          CMD_VIN_OFS:   rsp_next.data[31:0]       = {cfg.vin_on, cfg.vin_off};
          CMD_VOUT_TRIM: rsp_next.data[HALF_W-1:0] = cfg.vout_trim;
          default:       rsp_next.err = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
      cfg <= '{temp_sel: TEMP_SEL_RST, vin_on: VIN_OFS_RST[VIN_ON_LSB +: HALF_W],
               vin_off: VIN_OFS_RST[VIN_OFF_LSB +: HALF_W], vout_trim: VOUT_TRIM_RST};
    end else begin
      rsp <= rsp_next;
      cfg <= cfg_next;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  wire rd_ramp = cmd.valid && !cmd.write && cmd.code == CMD_RAMP_REC;
  wire rd_hist = cmd.valid && !cmd.write && cmd.code == CMD_STAT_HIST;

  chk_ramp_once_only: assert property (ramp_st_reg == RAMP_HELD |=> ramp_st_reg == RAMP_HELD [*3])
    else $error("ramp recorder left hold state");
  chk_rec_count_latch: assert property (ramp_st_reg == RAMP_IDLE && ramp_start && !ramp_ok
    |=> rec_cnt_reg == $past(snap_cycles) + CNT_W'(1))
    else $error("record counter not snapshot plus one");
  chk_ramp_good_clear: assert property (ramp_ok && ramp_st_reg != RAMP_IDLE
    |=> rec_cnt_reg == '0 && vin_mem_reg[0] == '0 && ramp_st_reg == RAMP_HELD)
    else $error("ramp record not cleared");
  chk_pair_spacing: assert property (ramp_st_reg == RAMP_CAPT && intv_cnt_reg < intv_last && !ramp_ok
    |=> pair_idx_reg == $past(pair_idx_reg))
    else $error("pair captured before interval ended");
  chk_pair_bound: assert property (ramp_st_reg == RAMP_CAPT |-> pair_idx_reg < 4'(RAMP_PAIRS))
    else $error("more than fifteen pairs");
  chk_ramp_read_block: assert property (rd_ramp
    |=> rsp.valid && rsp.len == LEN_BLOCK && rsp.data[CNT_W-1:0] == $past(rec_cnt_reg)
        && rsp.data[PAIR_LSB +: SAMPLE_W] == $past(vin_mem_reg[0]))
    else $error("ramp block reply wrong");
  chk_hist_read_block: assert property (rd_hist
    |=> rsp.valid && rsp.len == LEN_BLOCK && rsp.data[STAT_W-1:0] == $past(stat_mem_reg[0]))
    else $error("status block reply wrong");
  chk_hist_start_word: assert property (hist_st_reg == HIST_IDLE && ramp_done
    |=> hist_st_reg == HIST_RUN && word_idx_reg == 5'h1 && stat_mem_reg[0] == $past(status_word))
    else $error("history did not start at ramp end");
  chk_temp_sel_write: assert property (cmd.valid && cmd.write && cmd.code == CMD_TEMP_SEL
    |=> cfg.temp_sel[TEMP_EXT_BIT] == $past(cmd.wdata[TEMP_EXT_BIT]))
    else $error("sensor select not stored");
  chk_vin_ofs_write: assert property (cmd.valid && cmd.write && cmd.code == CMD_VIN_OFS
    |=> {cfg.vin_on, cfg.vin_off} == $past(cmd.wdata))
    else $error("input offsets not stored");
  chk_vout_trim_write: assert property (cmd.valid && cmd.write && cmd.code == CMD_VOUT_TRIM
    |=> cfg.vout_trim == $past(cmd.wdata[HALF_W-1:0]))
    else $error("output trim not stored");

  cov_ramp_full: cover property (ramp_st_reg == RAMP_CAPT && pair_idx_reg == 4'(RAMP_PAIRS - 1) ##1
                                 ramp_st_reg == RAMP_HELD);
  cov_hist_full: cover property (hist_st_reg == HIST_RUN ##1 hist_st_reg == HIST_FULL);
  cov_ramp_read: cover property (rd_ramp ##1 rsp.valid);

endmodule // rsc_ramp_status_regs

//--- tb/rsc_pwr_model.sv
// power stage stand-in: ramp events, voltage samples and status words
module rsc_pwr_model
  import rsc_pkg::*;
#(
  parameter int RAMP_CYC = 60,
  parameter int STAT_P   = 10
) (
  input  wire logic           core_clk,
  output logic                ramp_start,
  output logic                ramp_done,
  output logic                ramp_ok,
  output logic [31:0]         ramp_cycles,
  output logic [CNT_W-1:0]    snap_cycles,
  output logic [SAMPLE_W-1:0] vin_sample,
  output logic [SAMPLE_W-1:0] vout_sample,
  output logic [STAT_W-1:0]   status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IV = RAMP_CYC / 15;
  int         t_ramp = 0;
  int         t_stat = 0;
  logic [7:0] base;

  assign ramp_cycles = 32'(RAMP_CYC);

  // elapsed cycles; status count idles at 0 so word 0 reads step 0
  always @(posedge core_clk) begin
    t_ramp <= ramp_start ? 1 : t_ramp + 1;
    if (ramp_done) begin
      t_stat <= 1;
    end else if (t_stat != 0) begin
      t_stat <= t_stat + 1;
    end
  end

  // steps centred on capture instants, so a one-cycle skew reads the same step
  always @(negedge core_clk) begin
    vin_sample  <= base + 8'((t_ramp + IV / 2) / IV);
    vout_sample <= base + 8'h40 + 8'((t_ramp + IV / 2) / IV);
    status_word <= 16'hA000 + 16'((t_stat + STAT_P / 2 - 1) / STAT_P);
  end

  initial begin
    {ramp_start, ramp_done, ramp_ok, snap_cycles, base} = '0;
  end

  // one ramp: start, full capture time plus margin, then end
  task automatic ramp(input logic [15:0] snap, input logic [7:0] vb, input logic ok);
    @(negedge core_clk);
    base        = vb;
    snap_cycles = snap;
    ramp_start  = 1'b1;
    @(negedge core_clk);
    ramp_start = 1'b0;
    repeat (RAMP_CYC + 10) @(negedge core_clk);
    ramp_done = 1'b1;
    ramp_ok   = ok;
    @(negedge core_clk);
    ramp_done = 1'b0;
    ramp_ok   = 1'b0;
  endtask
endmodule // rsc_pwr_model

//--- tb/tb.sv
// self-checking bench for the ramp and status capture register bank
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module tb
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  rsc_cmd_s            cmd      = '0;
  rsc_rsp_s            rsp;
  rsc_rsp_s            r;
  rsc_cfg_s            cfg;
  logic                ramp_start, ramp_done, ramp_ok;
  logic [31:0]         ramp_cycles;
  logic [CNT_W-1:0]    snap_cycles;
  logic [SAMPLE_W-1:0] vin_sample, vout_sample;
  logic [STAT_W-1:0]   status_word;
  int                  num_errors   = 0;
  int                  total_checks = 0;

  always #4 core_clk = ~core_clk;

  rsc_ramp_status_regs #(.STAT_PERIOD(10)) u_rsc_ramp_status_regs (
    .core_clk(core_clk), .rstn(rstn), .cmd(cmd), .ramp_start(ramp_start), .ramp_done(ramp_done),
    .ramp_ok(ramp_ok), .ramp_cycles(ramp_cycles), .snap_cycles(snap_cycles), .vin_sample(vin_sample),
    .vout_sample(vout_sample), .status_word(status_word), .rsp(rsp), .cfg(cfg));

  rsc_pwr_model #(.RAMP_CYC(60), .STAT_P(10)) u_rsc_pwr_model (
    .core_clk(core_clk), .ramp_start(ramp_start), .ramp_done(ramp_done), .ramp_ok(ramp_ok),
    .ramp_cycles(ramp_cycles), .snap_cycles(snap_cycles), .vin_sample(vin_sample),
    .vout_sample(vout_sample), .status_word(status_word));

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one command; entered and left at a falling edge, reply waited for a few cycles only
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [31:0] wd);
    int i;
    cmd <= {1'b1, wr, code, wd};
    @(negedge core_clk);
    cmd.valid <= 1'b0;
    for (i = 0; i < 4 && rsp.valid !== 1'b1; i++) @(negedge core_clk);
    if (rsp.valid !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t no reply", $time);
      results();
    end
    r = rsp;
    // one idle cycle, so the next request is never set in this time step
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] code, input logic [5:0] len, input logic [255:0] exp, input logic err);
    xfer(1'b0, code, 32'h0);
    `CHK(r.err, err)
    `CHK(r.len, len)
    `CHK(r.data, exp)
  endtask

  task automatic wr(input logic [7:0] code, input logic [31:0] wd, input logic err);
    xfer(1'b1, code, wd);
    `CHK(r.err, err)
    `CHK(r.len, LEN_NONE)
  endtask

  // pair k holds step k+1 of the model's sample pattern
  function automatic logic [255:0] ramp_exp(input logic [15:0] cnt, input logic [7:0] vb);
    logic [255:0] e;
    int           k;
    e       = '0;
    e[15:0] = cnt;
    for (k = 0; k < RAMP_PAIRS; k++) begin
      e[PAIR_LSB + PAIR_STEP * k +: 8]     = vb + 8'(k + 1);
      e[PAIR_LSB + PAIR_STEP * k + 8 +: 8] = vb + 8'h40 + 8'(k + 1);
    end
    return e;
  endfunction

  function automatic logic [255:0] hist_exp();
    logic [255:0] e;
    int           k;
    for (k = 0; k < STAT_WORDS; k++) begin
      e[STAT_W * k +: 16] = 16'hA000 + 16'(k);
    end
    return e;
  endfunction

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (5) @(negedge core_clk);
    rstn <= 1'b1;
    rd(CMD_TEMP_SEL, LEN_BYTE, 256'h0, 1'b0);
    rd(CMD_VIN_OFS, LEN_DWORD, 256'h0, 1'b0);
    rd(CMD_VOUT_TRIM, LEN_WORD, 256'h0, 1'b0);
    wr(CMD_TEMP_SEL, 32'h0000_0001, 1'b0);
    `CHK(cfg.temp_sel[TEMP_EXT_BIT], 1'b1)
    rd(CMD_TEMP_SEL, LEN_BYTE, 256'h1, 1'b0);
    wr(CMD_VIN_OFS, 32'h1234_ABCD, 1'b0);
    `CHK({cfg.vin_on, cfg.vin_off}, 32'h1234_ABCD)
    rd(CMD_VIN_OFS, LEN_DWORD, 256'h1234_ABCD, 1'b0);
    wr(CMD_VOUT_TRIM, 32'hFFFF_8001, 1'b0);
    `CHK(cfg.vout_trim, 16'h8001)
    rd(CMD_VOUT_TRIM, LEN_WORD, 256'h8001, 1'b0);
    wr(CMD_TEMP_SEL, 32'h0000_0000, 1'b0);
    `CHK(cfg.temp_sel[TEMP_EXT_BIT], 1'b0)
    $display("test config done");
    wr(CMD_RAMP_REC, 32'h0000_00FF, 1'b1);
    wr(CMD_STAT_HIST, 32'h0000_00FF, 1'b1);
    rd(8'hE0, LEN_NONE, 256'h0, 1'b1);
    rd(CMD_RAMP_REC, LEN_BLOCK, 256'h0, 1'b0);
    $display("test refusal done");
    u_rsc_pwr_model.ramp(16'h0041, 8'h10, 1'b0);
    rd(CMD_RAMP_REC, LEN_BLOCK, ramp_exp(16'h0042, 8'h10), 1'b0);
    repeat (170) @(negedge core_clk);
    rd(CMD_STAT_HIST, LEN_BLOCK, hist_exp(), 1'b0);
    u_rsc_pwr_model.ramp(16'h0100, 8'h80, 1'b0);
    rd(CMD_RAMP_REC, LEN_BLOCK, ramp_exp(16'h0042, 8'h10), 1'b0);
    rd(CMD_STAT_HIST, LEN_BLOCK, hist_exp(), 1'b0);
    $display("test capture done");
    u_rsc_pwr_model.ramp(16'h0200, 8'h20, 1'b1);
    rd(CMD_RAMP_REC, LEN_BLOCK, 256'h0, 1'b0);
    $display("test clear done");
    results();
  end
endmodule // tb
